// ==== hrt_top.sv ====
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
// ------------------------------------------------------------
// Home reference tracker
// ------------------------------------------------------------
// Notes on behaviour
// - While armed, next selected home event copies actual position, or for centre codes the entry/exit midpoint, to home.
// - Arm bit clears itself once latch-done is cleared after a capture.
// - A capture sets latch-done in the event register.
// - Software writes overwrite the home position directly.
// - Eight event codes; high-active codes put home at centre, left, right.
// - Low-active codes put home at centre, right or left of low region.
// - Direction codes say low input lies on negative or positive side.
// - Home error flags input level inconsistent with home and event code.
// - Home error not evaluated inside home plus or minus margin, inclusive.
// - Left stop as home: event only after home range crossed.
// - Right stop as home: event only after home range crossed.
// - Arrival output follows actual equal to target position.
// - Arrival output high-active by default, bit 16 inverts it.
// - Event bits stay set until event register is read or written.
module hrt_top (
   input wire logic clk_in, // System clock, 50 MHz
   input wire logic reset_in, // Synchronous reset, high
   input wire logic [hrt_pkg::ADDR_W-1:0] address_in, // Register offset
   input wire logic [hrt_pkg::DATA_W-1:0] write_data_in, // Write data
   input wire logic write_strobe_in, // One-cycle write
   input wire logic read_strobe_in, // One-cycle read
   output logic [hrt_pkg::DATA_W-1:0] read_data_out, // Read data, cycle after strobe
   input wire logic [31:0] actual_position_in, // Signed actual position
   input wire logic [31:0] target_position_in, // Signed target position
   input wire logic home_switch_in, // Home switch level
   input wire logic left_stop_input_in, // Left stop switch level
   input wire logic right_stop_input_in, // Right stop switch level
   output logic arrival_out, // Target reached pin
   output logic home_error_out, // Live home error
   output logic latch_done_out, // Sticky latch-done event
   output logic stop_left_event_out, // Sticky left stop event
   output logic stop_right_event_out, // Sticky right stop event
   output logic [31:0] home_position_out // Home position register
);
   import hrt_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [31:0] general_config_r;
   logic [31:0] ref_config_r;
   logic [31:0] event_flags_r;
   logic [31:0] home_margin_r;
   logic signed [31:0] home_position_r;
   logic signed [31:0] prev_pos_r;
   logic signed [31:0] entry_pos_r;
   logic home_prev_r;
   logic captured_r;
   logic window_r;
   logic arrival_r;
   logic home_error_r;
   logic [2:0] sync_q;
   logic home_now;
   logic left_act;
   logic right_act;
   logic left_stop_pulse;
   logic right_stop_pulse;
   logic [3:0] event_code;
   logic [3:0] norm_code;
   logic home_act;
   logic home_act_prev;
   logic enter;
   logic leave;
   logic moving_pos;
   logic hit;
   logic capture;
   logic code_valid;
   logic expected_act;
   logic home_error_nxt;
   logic signed [31:0] pos;
   logic signed [31:0] cap_val;
   logic signed [32:0] mid_sum;
   logic signed [33:0] pos_w;
   logic signed [33:0] lo_w;
   logic signed [33:0] hi_w;
   logic wr_general;
   logic wr_ref;
   logic wr_margin;
   logic wr_home;
   logic ev_clear;
   logic arm_auto_clear;
   logic [31:0] ev_set;
   logic [31:0] read_mux;
   logic [31:0] status_word;

   assign pos = actual_position_in;

   // ------------------------------------------------------------
   // Switch input sampling
   // ------------------------------------------------------------
   hrt_sync #(
      .WIDTH(3)
   ) u_sync (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .async_in({right_stop_input_in, left_stop_input_in, home_switch_in}),
      .sync_out(sync_q)
   );

   assign home_now = sync_q[0];
   assign left_act = sync_q[1] ^ ref_config_r[RC_POL_LEFT];
   assign right_act = sync_q[2] ^ ref_config_r[RC_POL_RIGHT];

   // ------------------------------------------------------------
   // Home event decode
   // ------------------------------------------------------------
   // code folding
   // Low-active codes are bitwise complements of high-active ones, so fold them
   assign event_code = ref_config_r[RC_EVENT_MSB:RC_EVENT_LSB];
   assign norm_code = event_code[3] ? ~event_code : event_code;
   assign home_act = home_now ^ event_code[3];
   assign home_act_prev = home_prev_r ^ event_code[3];
   assign enter = home_act & ~home_act_prev;
   assign leave = ~home_act & home_act_prev;
   assign moving_pos = pos > prev_pos_r;
   assign mid_sum = {entry_pos_r[31], entry_pos_r} + {pos[31], pos};

   // Transition that marks home for each code
   always_comb begin
      hit = 1'b0;
      cap_val = pos;
      code_valid = 1'b1;
      expected_act = 1'b0;
      case (norm_code)
         HEV_DIRECTION: begin
            hit = enter | leave;
            expected_act = pos > home_position_r;
         end
         HEV_LEFT_EDGE: begin
            hit = (enter & moving_pos) | (leave & ~moving_pos);
         end
         HEV_RIGHT_EDGE: begin
            hit = (enter & ~moving_pos) | (leave & moving_pos);
         end
         HEV_CENTER: begin
            // Midpoint of entry and exit positions
            hit = leave;
            cap_val = mid_sum[32:1];
         end
         default: begin
            code_valid = 1'b0;
         end
      endcase
   end

   assign capture = ref_config_r[RC_ARM] & ~captured_r & hit;

   // Sampling history for edges, direction and centre entry
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         home_prev_r <= 1'b0;
         prev_pos_r <= '0;
         entry_pos_r <= '0;
      end else begin
         home_prev_r <= home_now;
         prev_pos_r <= pos;
         if (enter) begin
            entry_pos_r <= pos;
         end
      end
   end

   // ------------------------------------------------------------
   // Home range and error
   // ------------------------------------------------------------
   // inclusive window
   // 34-bit math so the bounds never wrap at the ends of the range
   assign pos_w = {{2{pos[31]}}, pos};
   assign lo_w = {{2{home_position_r[31]}}, home_position_r} - {2'b00, home_margin_r};
   assign hi_w = {{2{home_position_r[31]}}, home_position_r} + {2'b00, home_margin_r};

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         window_r <= 1'b0;
      end else begin
         window_r <= (pos_w >= lo_w) && (pos_w <= hi_w);
      end
   end

   // live error
   // Region codes expect the input inactive outside the margin, so the
   // margin has to cover the whole active region to stay quiet
   assign home_error_nxt = code_valid & ~window_r & (home_act != expected_act);

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         home_error_r <= 1'b0;
      end else begin
         home_error_r <= home_error_nxt;
      end
   end

   // ------------------------------------------------------------
   // Stop switches
   // ------------------------------------------------------------
   hrt_stop_gate u_left_gate (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .active_in(left_act),
      .as_home_in(ref_config_r[RC_LEFT_AS_HOME]),
      .in_window_in(window_r),
      .event_out(left_stop_pulse)
   );

   hrt_stop_gate u_right_gate (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .active_in(right_act),
      .as_home_in(ref_config_r[RC_RIGHT_AS_HOME]),
      .in_window_in(window_r),
      .event_out(right_stop_pulse)
   );

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   assign wr_general = write_strobe_in && (address_in == REG_GENERAL_CONFIG);
   assign wr_ref = write_strobe_in && (address_in == REG_REF_SWITCH_CONFIG);
   assign wr_margin = write_strobe_in && (address_in == REG_HOME_MARGIN);
   assign wr_home = write_strobe_in && (address_in == REG_HOME_POSITION);
   assign ev_clear = (write_strobe_in || read_strobe_in) && (address_in == REG_EVENT_FLAGS);
   assign arm_auto_clear = ev_clear & event_flags_r[EV_LATCH_DONE] & captured_r;

   // Plain configuration registers
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         general_config_r <= GENERAL_CONFIG_RST;
         home_margin_r <= HOME_MARGIN_RST;
      end else begin
         if (wr_general) begin
            general_config_r <= write_data_in;
         end
         if (wr_margin) begin
            home_margin_r <= write_data_in;
         end
      end
   end

   // Reference config; a software write beats the automatic disarm
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ref_config_r <= REF_SWITCH_CONFIG_RST;
      end else if (wr_ref) begin
         ref_config_r <= write_data_in;
      end else if (arm_auto_clear) begin
         ref_config_r[RC_ARM] <= 1'b0;
      end
   end

   // Capture bookkeeping, rearmed by any write to the reference config
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         captured_r <= 1'b0;
      end else if (wr_ref || !ref_config_r[RC_ARM]) begin
         captured_r <= 1'b0;
      end else if (capture) begin
         captured_r <= 1'b1;
      end
   end

   // home position
   // A direct software write takes precedence over a capture in the same cycle
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         home_position_r <= HOME_POSITION_RST;
      end else if (wr_home) begin
         home_position_r <= write_data_in;
      end else if (capture) begin
         home_position_r <= cap_val;
      end
   end

   // sticky events
   // New events win over a clear in the same cycle
   always_comb begin
      ev_set = '0;
      ev_set[EV_LATCH_DONE] = capture;
      ev_set[EV_STOP_LEFT] = left_stop_pulse;
      ev_set[EV_STOP_RIGHT] = right_stop_pulse;
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         event_flags_r <= '0;
      end else begin
         event_flags_r <= (ev_clear ? '0 : event_flags_r) | ev_set;
      end
   end

   // Status word of live state
   always_comb begin
      status_word = '0;
      status_word[ST_HOME_ERROR] = home_error_r;
      status_word[ST_ARRIVAL] = arrival_r;
      status_word[ST_LEFT_ACTIVE] = left_act;
      status_word[ST_RIGHT_ACTIVE] = right_act;
      status_word[ST_ARMED] = ref_config_r[RC_ARM];
   end

   // Read decode; unmapped offsets read as zero
   always_comb begin
      case (address_in)
         REG_GENERAL_CONFIG: read_mux = general_config_r;
         REG_REF_SWITCH_CONFIG: read_mux = ref_config_r;
         REG_EVENT_FLAGS: read_mux = event_flags_r;
         REG_HOME_MARGIN: read_mux = home_margin_r;
         REG_HOME_POSITION: read_mux = home_position_r;
         REG_STATUS: read_mux = status_word;
         default: read_mux = '0;
      endcase
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         read_data_out <= '0;
      end else begin
         read_data_out <= read_strobe_in ? read_mux : '0;
      end
   end

   // ------------------------------------------------------------
   // Arrival output
   // ------------------------------------------------------------
   // arrival polarity
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         arrival_r <= 1'b0;
         arrival_out <= 1'b0;
      end else begin
         arrival_r <= actual_position_in == target_position_in;
         arrival_out <= (actual_position_in == target_position_in) ^ general_config_r[GC_INVERT_ARRIVAL];
      end
   end

   // Mirror outputs straight from flops
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         home_error_out <= 1'b0;
         latch_done_out <= 1'b0;
         stop_left_event_out <= 1'b0;
         stop_right_event_out <= 1'b0;
         home_position_out <= '0;
      end else begin
         home_error_out <= home_error_nxt;
         latch_done_out <= (ev_clear ? 1'b0 : event_flags_r[EV_LATCH_DONE]) | capture;
         stop_left_event_out <= (ev_clear ? 1'b0 : event_flags_r[EV_STOP_LEFT]) | left_stop_pulse;
         stop_right_event_out <= (ev_clear ? 1'b0 : event_flags_r[EV_STOP_RIGHT]) | right_stop_pulse;
         home_position_out <= wr_home ? write_data_in : (capture ? cap_val : home_position_r);
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_capture_takes_pos: assert property (@(posedge clk_in) disable iff (reset_in)
      (capture && !wr_home) |=> (home_position_r == $past(cap_val)))
      else $error("home position did not take the captured value");

   a_capture_sets_done: assert property (@(posedge clk_in) disable iff (reset_in)
      capture |=> (event_flags_r[EV_LATCH_DONE] && latch_done_out))
      else $error("capture did not raise latch-done");

   a_arm_auto_clear: assert property (@(posedge clk_in) disable iff (reset_in)
      (arm_auto_clear && !wr_ref) |=> (!ref_config_r[RC_ARM] ##1 !captured_r))
      else $error("arm bit not cleared after latch-done clear");

   a_home_sw_write: assert property (@(posedge clk_in) disable iff (reset_in)
      wr_home |=> (home_position_r == $past(write_data_in) && home_position_out == home_position_r))
      else $error("software write to home position lost");

   a_window_masks_err: assert property (@(posedge clk_in) disable iff (reset_in)
      window_r |=> (!home_error_r && !home_error_out))
      else $error("home error raised inside margin window");

   a_error_raised: assert property (@(posedge clk_in) disable iff (reset_in)
      (code_valid && !window_r && (home_act != expected_act)) |=> home_error_r)
      else $error("inconsistent home level gave no error");

   a_error_is_live: assert property (@(posedge clk_in) disable iff (reset_in)
      (!code_valid) |=> !home_error_r)
      else $error("home error set with no valid event code");

   a_event_holds: assert property (@(posedge clk_in) disable iff (reset_in)
      (event_flags_r[EV_STOP_LEFT] && !ev_clear) |=> event_flags_r[EV_STOP_LEFT])
      else $error("sticky event dropped without a clear");

   a_event_clears: assert property (@(posedge clk_in) disable iff (reset_in)
      (ev_clear && !capture) |=> !event_flags_r[EV_LATCH_DONE])
      else $error("latch-done survived a clear");

   a_arrival_flag: assert property (@(posedge clk_in) disable iff (reset_in)
      (actual_position_in == target_position_in) |=> arrival_r)
      else $error("arrival flag missing at target");

   a_arrival_pol: assert property (@(posedge clk_in) disable iff (reset_in)
      !$past(reset_in) |-> (arrival_out == (arrival_r ^ $past(general_config_r[GC_INVERT_ARRIVAL]))))
      else $error("arrival pin polarity wrong");
endmodule : hrt_top

// ==== hrt_pkg.sv ====
// ------------------------------------------------------------
// Home reference tracker constants
// ------------------------------------------------------------
package hrt_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register offsets (plain port, word per offset)
   localparam logic [7:0] REG_GENERAL_CONFIG = 8'h00;
   localparam logic [7:0] REG_REF_SWITCH_CONFIG = 8'h01;
   localparam logic [7:0] REG_EVENT_FLAGS = 8'h0e;
   localparam logic [7:0] REG_HOME_MARGIN = 8'h1e;
   localparam logic [7:0] REG_HOME_POSITION = 8'h20;
   localparam logic [7:0] REG_STATUS = 8'h21;

   // Reset values
   localparam logic [31:0] GENERAL_CONFIG_RST = 32'h0000_0000;
   localparam logic [31:0] REF_SWITCH_CONFIG_RST = 32'h0000_0000;
   localparam logic [31:0] HOME_MARGIN_RST = 32'h0000_0000;
   localparam logic [31:0] HOME_POSITION_RST = 32'h0000_0000;

   // general_config fields
   localparam int GC_INVERT_ARRIVAL = 16;

   // reference_switch_config fields
   localparam int RC_ARM = 0;
   localparam int RC_EVENT_LSB = 1;
   localparam int RC_EVENT_MSB = 4;
   localparam int RC_LEFT_AS_HOME = 5;
   localparam int RC_RIGHT_AS_HOME = 6;
   localparam int RC_POL_LEFT = 7;
   localparam int RC_POL_RIGHT = 8;

   // event_flags fields
   localparam int EV_LATCH_DONE = 0;
   localparam int EV_STOP_LEFT = 1;
   localparam int EV_STOP_RIGHT = 2;

   // status fields
   localparam int ST_HOME_ERROR = 0;
   localparam int ST_ARRIVAL = 1;
   localparam int ST_LEFT_ACTIVE = 2;
   localparam int ST_RIGHT_ACTIVE = 3;
   localparam int ST_ARMED = 4;

   // Home event codes, high-active form; low-active codes are their complements
   localparam logic [3:0] HEV_DIRECTION = 4'h3;
   localparam logic [3:0] HEV_CENTER = 4'h6;
   localparam logic [3:0] HEV_LEFT_EDGE = 4'h2;
   localparam logic [3:0] HEV_RIGHT_EDGE = 4'h4;

   // Synchroniser depth
   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0] {STP_IDLE, STP_WAIT_ENTER, STP_WAIT_EXIT} hrt_stop_state_t;
endpackage : hrt_pkg

// ==== hrt_sync.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// Two-stage level synchroniser
// ------------------------------------------------------------
module hrt_sync #(
   parameter int WIDTH = 3
) (
   input wire logic clk_in, // System clock
   input wire logic reset_in, // Synchronous reset, high
   input wire logic [WIDTH-1:0] async_in, // Raw switch levels
   output logic [WIDTH-1:0] sync_out // Synchronised levels
);
   import hrt_pkg::*;

   logic [WIDTH-1:0] meta_r;

   // two flop sync
   // First stage is read only by the second stage
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end

   a_sync_two_cycle: assert property (@(posedge clk_in) disable iff (reset_in)
      (!$past(reset_in) && !$past(reset_in, 2)) |-> (sync_out == $past(async_in, 2)))
      else $error("synchroniser delay is not two cycles");
endmodule : hrt_sync

// ==== hrt_stop_gate.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// Stop event generator with optional home-range gating
// ------------------------------------------------------------
module hrt_stop_gate (
   input wire logic clk_in, // System clock
   input wire logic reset_in, // Synchronous reset, high
   input wire logic active_in, // Stop input at active level
   input wire logic as_home_in, // Stop input doubles as home switch
   input wire logic in_window_in, // Position inside home range
   output logic event_out // One-cycle stop event
);
   import hrt_pkg::*;

   logic active_prev_r;
   logic rise;
   hrt_stop_state_t state_r;

   assign rise = active_in & ~active_prev_r;

   // Previous level for edge detection
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         active_prev_r <= 1'b0;
      end else begin
         active_prev_r <= active_in;
      end
   end

   // range crossing
   // Gated mode fires only after the range was entered and then left
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_r <= STP_IDLE;
         event_out <= 1'b0;
      end else begin
         event_out <= 1'b0;
         case (state_r)
            STP_IDLE: begin
               if (rise && !as_home_in) begin
                  event_out <= 1'b1;
               end else if (rise) begin
                  state_r <= in_window_in ? STP_WAIT_EXIT : STP_WAIT_ENTER;
               end
            end
            STP_WAIT_ENTER: begin
               if (!active_in || !as_home_in) begin
                  state_r <= STP_IDLE;
               end else if (in_window_in) begin
                  state_r <= STP_WAIT_EXIT;
               end
            end
            STP_WAIT_EXIT: begin
               if (!active_in || !as_home_in) begin
                  state_r <= STP_IDLE;
               end else if (!in_window_in) begin
                  event_out <= 1'b1;
                  state_r <= STP_IDLE;
               end
            end
            default: begin
               state_r <= STP_IDLE;
            end
         endcase
      end
   end

   a_stop_gated_wait: assert property (@(posedge clk_in) disable iff (reset_in)
      (as_home_in && state_r == STP_WAIT_ENTER) |=> !event_out)
      else $error("gated stop fired before home range was crossed");

   a_stop_plain_edge: assert property (@(posedge clk_in) disable iff (reset_in)
      (!as_home_in && state_r == STP_IDLE && rise) |=> event_out)
      else $error("ungated stop edge gave no event");
endmodule : hrt_stop_gate

// ==== hrt_switch_model.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// Switch partner model
// ------------------------------------------------------------
module hrt_switch_model (
   input wire logic clk_in, // System clock
   input wire logic [2:0] level_in, // Wanted home, left, right levels
   output logic [2:0] pin_out // Raw switch pins
);
   // Pins start released and low, so no unknown reaches the sync flops
   initial pin_out = 3'h0;
   // raw async levels
   // Contacts move one cycle late, so the pin never lines up with the bench edge
   always @(posedge clk_in) begin
      pin_out <= level_in;
   end
endmodule : hrt_switch_model

// ==== home_reference_tracker_test.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// Home reference tracker bench
// ------------------------------------------------------------
module home_reference_tracker_test;
   import hrt_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] e;} hrt_row_t;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic wr = 1'b0, rd = 1'b0, arr, herr, ldone, sl, sr;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, act = 32'h0, tgt = 32'h0, rdata, hpos, got;
   logic [2:0] lvl = 3'h0, pins;
   int errors = 0, n_compared = 0;
   // Reset values, read-only status and an unmapped offset
   hrt_row_t rows [7] = '{'{REG_GENERAL_CONFIG, 32'h0}, '{REG_REF_SWITCH_CONFIG, 32'h0},
      '{REG_EVENT_FLAGS, 32'h0}, '{REG_HOME_MARGIN, 32'h0}, '{REG_HOME_POSITION, 32'h0},
      '{REG_STATUS, 32'h2}, '{8'h40, 32'h0}};
   always #10 clk_in = ~clk_in;
   hrt_switch_model u_sw (.clk_in(clk_in), .level_in(lvl), .pin_out(pins));
   hrt_top u_dut (.clk_in(clk_in), .reset_in(reset_in), .address_in(addr), .write_data_in(wdata),
      .write_strobe_in(wr), .read_strobe_in(rd), .read_data_out(rdata), .actual_position_in(act),
      .target_position_in(tgt), .home_switch_in(pins[0]), .left_stop_input_in(pins[1]),
      .right_stop_input_in(pins[2]), .arrival_out(arr), .home_error_out(herr), .latch_done_out(ldone),
      .stop_left_event_out(sl), .stop_right_event_out(sr), .home_position_out(hpos));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : cyc
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
      #1;
   endtask : wr_reg
   // Read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         errors++;
      end
   endtask : chk
   task automatic summarize();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   // Main sequence: table first, then hand-written cases
   initial begin
      repeat (3) @(posedge clk_in);
      reset_in <= 1'b0;
      foreach (rows[i]) begin
         rd_reg(rows[i].a, got);
         chk("register", rows[i].e, got);
      end
      @(posedge clk_in) act <= 32'h5;
      cyc(2);
      chk("arrival away", 32'h0, {31'h0, arr});
      @(posedge clk_in) tgt <= 32'h5;
      cyc(2);
      chk("arrival", 32'h1, {31'h0, arr});
      wr_reg(REG_GENERAL_CONFIG, 32'h0001_0000);
      cyc(2);
      chk("arrival inverted", 32'h0, {31'h0, arr});
      @(posedge clk_in) tgt <= 32'h6;
      cyc(2);
      chk("arrival inverted off", 32'h1, {31'h0, arr});
      wr_reg(REG_HOME_POSITION, 32'h1234);
      chk("home position write", 32'h1234, hpos);
      @(posedge clk_in) act <= 32'h100;
      wr_reg(REG_REF_SWITCH_CONFIG, 32'h7);
      @(posedge clk_in) lvl <= 3'h1;
      cyc(6);
      chk("home capture", 32'h100, hpos);
      chk("latch done", 32'h1, {31'h0, ldone});
      cyc(5);
      chk("latch done held", 32'h1, {31'h0, ldone});
      rd_reg(REG_EVENT_FLAGS, got);
      chk("events", 32'h1, got);
      cyc(2);
      chk("latch done cleared", 32'h0, {31'h0, ldone});
      rd_reg(REG_REF_SWITCH_CONFIG, got);
      chk("arm cleared", 32'h6, got);
      @(posedge clk_in) act <= 32'h50;
      cyc(4);
      chk("home error", 32'h1, {31'h0, herr});
      wr_reg(REG_HOME_MARGIN, 32'hb0);
      cyc(3);
      chk("margin edge", 32'h0, {31'h0, herr});
      wr_reg(REG_HOME_MARGIN, 32'haf);
      cyc(3);
      chk("margin outside", 32'h1, {31'h0, herr});
      @(posedge clk_in) act <= 32'h200;
      cyc(4);
      chk("home consistent", 32'h0, {31'h0, herr});
      wr_reg(REG_REF_SWITCH_CONFIG, 32'h26);
      @(posedge clk_in) lvl <= 3'h3;
      cyc(6);
      chk("left stop gated", 32'h0, {31'h0, sl});
      @(posedge clk_in) act <= 32'h100;
      cyc(3);
      @(posedge clk_in) act <= 32'h300;
      cyc(4);
      chk("left stop crossed", 32'h1, {31'h0, sl});
      // Ungated right stop fires on its rising edge
      @(posedge clk_in) lvl <= 3'h7;
      cyc(6);
      chk("right stop plain", 32'h1, {31'h0, sr});
      rd_reg(REG_EVENT_FLAGS, got);
      chk("stop events", 32'h6, got);
      // Centre code: home is the midpoint of entry and exit positions
      @(posedge clk_in) lvl <= 3'h0;
      act <= 32'h400;
      cyc(4);
      wr_reg(REG_REF_SWITCH_CONFIG, 32'hd);
      @(posedge clk_in) lvl <= 3'h1;
      cyc(6);
      @(posedge clk_in) lvl <= 3'h0;
      act <= 32'h500;
      cyc(6);
      chk("centre capture", 32'h480, hpos);
      // Low-active left edge: leaving the low region while standing still
      wr_reg(REG_REF_SWITCH_CONFIG, 32'h1b);
      @(posedge clk_in) act <= 32'h600;
      cyc(2);
      @(posedge clk_in) lvl <= 3'h1;
      cyc(6);
      chk("low left edge capture", 32'h600, hpos);
      // Low-active direction code: low input expected above home
      wr_reg(REG_REF_SWITCH_CONFIG, 32'h18);
      @(posedge clk_in) act <= 32'h800;
      cyc(4);
      chk("low direction error", 32'h1, {31'h0, herr});
      @(posedge clk_in) lvl <= 3'h0;
      cyc(6);
      chk("low direction ok", 32'h0, {31'h0, herr});
      // Reset in mid-run clears the registers again
      @(posedge clk_in) reset_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      reset_in <= 1'b0;
      rd_reg(REG_HOME_MARGIN, got);
      chk("margin after reset", 32'h0, got);
      chk("home after reset", 32'h0, hpos);
      summarize();
   end
   // Watchdog: the sequence needs about 150 cycles
   initial begin
      #20000;
      errors++;
      summarize();
   end
endmodule : home_reference_tracker_test
